// *** core/clk_failover_pkg.sv ***
package clk_failover_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the AHB-Lite slave).
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
  localparam logic [7:0] RATE_OFS = 8'h10;

  // ---------------------------------------------------------------
  // Control register fields.
  // ---------------------------------------------------------------
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 2;
  localparam int CONV12_BIT = 2;
  localparam int CONV34_BIT = 3;
  localparam logic [1:0] SEL_INTERNAL = 2'h0;
  localparam logic [1:0] SEL_WORD = 2'h1;
  localparam logic [1:0] SEL_AES = 2'h2;
  localparam logic [1:0] CONV_RST = 2'h3;

  // Interrupt status and mask bits.
  localparam int EV_WC_LOST = 0;
  localparam int EV_WC_BACK = 1;
  localparam int EV_AES_LOST = 2;
  localparam int EV_AES_BACK = 3;
  localparam int EV_REJECT = 4;
  localparam int EV_W = 5;

  // Status register fields.
  localparam int ST_SRC_LSB = 0;
  localparam int ST_WC_VALID = 2;
  localparam int ST_AES_VALID = 3;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_CONV_LSB = 6;

  // Word clock connector switch positions.
  localparam logic [1:0] MODE_TERM_IN = 2'h0;
  localparam logic [1:0] MODE_OPEN_IN = 2'h1;
  localparam logic [1:0] MODE_OUT = 2'h2;

  // ---------------------------------------------------------------
  // Timing.
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int LOSS_TIMEOUT_NS = 50000;
  localparam int LOSS_TIMEOUT_CYC = LOSS_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int STABLE_RUN = 8;
  localparam int GAP_W = 16;
  localparam int RATE_W = 16;
  localparam logic [RATE_W-1:0] RATE_RST = 16'h0068;

  typedef enum logic [2:0] {
    ST_INTERNAL,
    ST_ON_WORD,
    ST_HOLD_WORD,
    ST_ON_AES,
    ST_HOLD_AES
  } fo_state_type;

endpackage

// *** core/clk_mon_if.sv ***
// Carries one monitored clock line and its validity verdict.
interface clk_mon_if;
  logic level;
  logic valid;
  logic lost;
  logic found;
  modport mon (input level, output valid, output lost, output found);
  modport ctl (output level, input valid, input lost, input found);
endinterface

// *** core/clk_monitor.sv ***
module clk_monitor
  import clk_failover_pkg::*;
#(
  parameter int TIMEOUT_CYC = LOSS_TIMEOUT_CYC,
  parameter int RUN_LEN = STABLE_RUN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  clk_mon_if.mon mon
);

  // ---------------------------------------------------------------
  // Edge spacing watchdog.
  // ---------------------------------------------------------------
  logic prev_r;
  logic valid_r;
  logic lost_r;
  logic found_r;
  logic [GAP_W-1:0] gap_r;
  logic [GAP_W-1:0] gap_nxt;
  logic [7:0] run_r;
  logic [7:0] run_nxt;
  logic valid_nxt;
  wire edge_seen = mon.level ^ prev_r;
  wire timeout = (gap_r == GAP_W'(TIMEOUT_CYC - 1));
  wire run_full = (run_r == 8'(RUN_LEN));

  // Any transition counts, so a biphase stream with silent audio still
  // shows edges every bit cell and keeps the source alive.
  assign gap_nxt = edge_seen ? '0 : (timeout ? gap_r : gap_r + 1'b1);
  // A gap longer than the timeout drops validity and restarts the run.
  assign run_nxt = timeout ? '0 : ((edge_seen && !run_full) ? run_r + 1'b1 : run_r);
  assign valid_nxt = timeout ? 1'b0 : (run_full ? 1'b1 : valid_r);

  // The pulses mark the moment the verdict changes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
      gap_r <= '0;
      run_r <= '0;
      valid_r <= 1'b0;
      lost_r <= 1'b0;
      found_r <= 1'b0;
    end else if (ce) begin
      prev_r <= mon.level;
      gap_r <= gap_nxt;
      run_r <= run_nxt;
      valid_r <= valid_nxt;
      lost_r <= valid_r & ~valid_nxt;
      found_r <= ~valid_r & valid_nxt;
    end
  end

  assign mon.valid = valid_r;
  assign mon.lost = lost_r;
  assign mon.found = found_r;

endmodule

// *** core/clk_failover.sv ***
// Overview of operation
// - Word clock in use and valid: green.
// - Word clock lost: red, run internal clock.
// - Word clock back: switch back, green again.
// - Output mode drives network clock, follows rate.
// - Recover clock from AES3 even without audio.
// - Only AES3 pair one/two serves as clock.
// - AES3 clock in use: AES indicator green.
// - AES3 clock lost: red, run internal clock.
// - AES3 clock back: switch back, green again.
// - AES3 select with the pair one/two converter on is refused.
// - Connector modes: terminated, open input, output.
module clk_failover
  import clk_failover_pkg::*;
#(
  parameter int TIMEOUT_CYC = LOSS_TIMEOUT_CYC,
  parameter int RUN_LEN = STABLE_RUN
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic WCLK_IN,
  output logic WCLK_OUT,
  output logic WCLK_OE,
  output logic WCLK_TERM,
  input wire logic [1:0] WCLK_SW,
  input wire logic AES12_IN,
  output logic [1:0] NET_SRC,
  output logic [1:0] CONV_EN,
  output logic WC_LED_GRN,
  output logic WC_LED_RED,
  output logic AES_LED_GRN,
  output logic AES_LED_RED,
  output logic IRQ
);

  // ---------------------------------------------------------------
  // Reset release and pin synchronisers.
  // ---------------------------------------------------------------
  logic rst_s1_r;
  logic rst_s2_r;
  wire rst_n = rst_s2_r;

  // Reset asserts at once but leaves on two clean edges.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // Only the first AES3 pair has a pin here; other pairs never reach
  // the clock logic.
  wire [3:0] pin_raw = {WCLK_SW, AES12_IN, WCLK_IN};
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      // Two stages per pin; only the second is read by logic.
      always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
          pin_s1_r[gi] <= 1'b0;
          pin_s2_r[gi] <= 1'b0;
        end else if (CLK_EN) begin
          pin_s1_r[gi] <= pin_raw[gi];
          pin_s2_r[gi] <= pin_s1_r[gi];
        end
      end
    end
  endgenerate

  wire [1:0] sw_mode = pin_s2_r[3:2];
  wire mode_out = (sw_mode == MODE_OUT);

  // ---------------------------------------------------------------
  // Clock validity monitors: index 0 word clock, index 1 AES3.
  // ---------------------------------------------------------------
  clk_mon_if mon_bus[2] ();
  wire [1:0] src_valid;
  wire [1:0] src_lost;
  wire [1:0] src_found;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_mon
      assign mon_bus[gi].level = pin_s2_r[gi];
      assign src_valid[gi] = mon_bus[gi].valid;
      assign src_lost[gi] = mon_bus[gi].lost;
      assign src_found[gi] = mon_bus[gi].found;
      clk_monitor #(
        .TIMEOUT_CYC(TIMEOUT_CYC),
        .RUN_LEN(RUN_LEN)
      ) u_mon (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .ce(CLK_EN),
        .mon(mon_bus[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // AHB-Lite slave.
  // ---------------------------------------------------------------
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [SEL_W-1:0] sel_r;
  logic [1:0] conv_r;
  logic [EV_W-1:0] irq_stat_r;
  logic [EV_W-1:0] irq_mask_r;
  logic [RATE_W-1:0] rate_r;
  fo_state_type state_r;
  fo_state_type state_nxt;

  wire addr_ok = HSEL & HTRANS[1] & HREADY;
  wire rd_req = addr_ok & ~HWRITE;
  wire [7:0] rd_addr = HADDR[7:0];
  wire wr_now = wr_pend_r;
  wire wr_ctrl = wr_now & (wr_addr_r == CTRL_OFS);
  wire wr_clr = wr_now & (wr_addr_r == IRQ_STAT_OFS);
  wire wr_mask = wr_now & (wr_addr_r == IRQ_MASK_OFS);
  wire wr_rate = wr_now & (wr_addr_r == RATE_OFS);

  // Refuse the AES3 source while pair one/two's converter stays on,
  // and refuse turning that converter on under an AES3 source.
  wire [SEL_W-1:0] new_sel = HWDATA[SEL_LSB +: SEL_W];
  wire new_conv12 = HWDATA[CONV12_BIT];
  wire reject = wr_ctrl & (new_conv12 & (new_sel == SEL_AES));
  wire [SEL_W-1:0] sel_nxt = (wr_ctrl && !reject) ? new_sel : sel_r;
  wire [1:0] conv_nxt = (wr_ctrl && !reject) ?
                        {HWDATA[CONV34_BIT], new_conv12} : conv_r;

  // Read multiplexer; unmapped addresses read as zero.
  wire [31:0] stat_word = 32'({conv_r, sw_mode, src_valid, NET_SRC});
  wire [31:0] ctrl_word = 32'({conv_r, sel_r});
  wire [31:0] rd_data =
    (rd_addr == CTRL_OFS) ? ctrl_word :
    (rd_addr == STAT_OFS) ? stat_word :
    (rd_addr == IRQ_STAT_OFS) ? 32'(irq_stat_r) :
    (rd_addr == IRQ_MASK_OFS) ? 32'(irq_mask_r) :
    (rd_addr == RATE_OFS) ? 32'(rate_r) : 32'h0000_0000;

  // Every transfer completes without wait states with an OKAY answer.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else if (CLK_EN) begin
      wr_pend_r <= addr_ok & HWRITE;
      wr_addr_r <= rd_addr;
      if (rd_req) begin
        HRDATA <= rd_data;
      end
    end
  end

  // Software-held configuration.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= SEL_INTERNAL;
      conv_r <= CONV_RST;
      irq_mask_r <= '0;
      rate_r <= RATE_RST;
    end else if (CLK_EN) begin
      sel_r <= sel_nxt;
      conv_r <= conv_nxt;
      if (wr_mask) begin
        irq_mask_r <= HWDATA[EV_W-1:0];
      end
      if (wr_rate) begin
        rate_r <= HWDATA[RATE_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Failover state machine.
  // ---------------------------------------------------------------
  // With the switch at output the word clock pin is ours, so the word
  // clock source falls back to internal clock.
  wire want_word = (sel_r == SEL_WORD) & ~mode_out;
  wire want_aes = (sel_r == SEL_AES);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_INTERNAL: begin
        if (want_word) begin
          state_nxt = src_valid[0] ? ST_ON_WORD : ST_HOLD_WORD;
        end else if (want_aes) begin
          state_nxt = src_valid[1] ? ST_ON_AES : ST_HOLD_AES;
        end
      end
      ST_ON_WORD: begin
        if (!want_word) begin
          state_nxt = ST_INTERNAL;
        end else if (!src_valid[0]) begin
          state_nxt = ST_HOLD_WORD;
        end
      end
      ST_HOLD_WORD: begin
        if (!want_word) begin
          state_nxt = ST_INTERNAL;
        end else if (src_valid[0]) begin
          state_nxt = ST_ON_WORD;
        end
      end
      ST_ON_AES: begin
        if (!want_aes) begin
          state_nxt = ST_INTERNAL;
        end else if (!src_valid[1]) begin
          state_nxt = ST_HOLD_AES;
        end
      end
      ST_HOLD_AES: begin
        if (!want_aes) begin
          state_nxt = ST_INTERNAL;
        end else if (src_valid[1]) begin
          state_nxt = ST_ON_AES;
        end
      end
      default: begin
        state_nxt = ST_INTERNAL;
      end
    endcase
  end

  // Network source follows the state; holding states run internally.
  wire [1:0] src_nxt = (state_nxt == ST_ON_WORD) ? SEL_WORD :
                       (state_nxt == ST_ON_AES) ? SEL_AES : SEL_INTERNAL;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_INTERNAL;
      NET_SRC <= SEL_INTERNAL;
      CONV_EN <= CONV_RST;
    end else if (CLK_EN) begin
      state_r <= state_nxt;
      NET_SRC <= src_nxt;
      CONV_EN <= conv_nxt;
    end
  end

  // Indicators: green while the source is in use, red while it is
  // selected but missing, dark otherwise.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WC_LED_GRN <= 1'b0;
      WC_LED_RED <= 1'b0;
      AES_LED_GRN <= 1'b0;
      AES_LED_RED <= 1'b0;
    end else if (CLK_EN) begin
      WC_LED_GRN <= (state_nxt == ST_ON_WORD);
      WC_LED_RED <= (state_nxt == ST_HOLD_WORD);
      AES_LED_GRN <= (state_nxt == ST_ON_AES);
      AES_LED_RED <= (state_nxt == ST_HOLD_AES);
    end
  end

  // ---------------------------------------------------------------
  // Events and interrupt.
  // ---------------------------------------------------------------
  // Loss and return events only count while that source is selected.
  wire [EV_W-1:0] ev_set = {reject,
                            src_found[1] & want_aes, src_lost[1] & want_aes,
                            src_found[0] & want_word, src_lost[0] & want_word};
  wire [EV_W-1:0] ev_clr = wr_clr ? HWDATA[EV_W-1:0] : '0;
  // A new event in the clearing cycle survives the clear.
  wire [EV_W-1:0] irq_stat_nxt = (irq_stat_r & ~ev_clr) | ev_set;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= '0;
      IRQ <= 1'b0;
    end else if (CLK_EN) begin
      irq_stat_r <= irq_stat_nxt;
      IRQ <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // Word clock output.
  // ---------------------------------------------------------------
  // The divider restarts on every rate write so a new network rate
  // takes effect at once instead of after a stale half period.
  logic [RATE_W-1:0] div_r;
  wire div_end = (div_r >= rate_r - 1'b1);
  wire [RATE_W-1:0] div_nxt = (wr_rate || div_end) ? '0 : div_r + 1'b1;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
      WCLK_OUT <= 1'b0;
      WCLK_OE <= 1'b0;
      WCLK_TERM <= 1'b0;
    end else if (CLK_EN) begin
      div_r <= div_nxt;
      if (div_end && !wr_rate) begin
        WCLK_OUT <= ~WCLK_OUT;
      end
      WCLK_OE <= mode_out;
      WCLK_TERM <= (sw_mode == MODE_TERM_IN);
    end
  end

  // HSIZE is accepted as word only; other sizes are not decoded.
  wire unused_ok = &{1'b0, HSIZE, HADDR[31:8]};

endmodule

// *** sim/clk_src_model.sv ***
module clk_src_model (
  input wire logic run,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ns;

  initial line = 1'b0;

  // An 800 ns clock; no edges come while stopped, so the line stands still.
  // Any transition stream will do, whether or not it carries audio.
  always begin
    #400;
    if (run) begin
      line = !line;
    end
  end
endmodule

// *** sim/clk_failover_asserts.sv ***
module clk_failover_asserts
  import clk_failover_pkg::*;
#(
  parameter int TIMEOUT_CYC = LOSS_TIMEOUT_CYC,
  parameter int RUN_LEN = STABLE_RUN
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  input wire logic WCLK_IN,
  input wire logic [1:0] WCLK_SW,
  input wire logic WCLK_OE,
  input wire logic WCLK_TERM,
  input wire logic [1:0] NET_SRC,
  input wire logic [1:0] CONV_EN,
  input wire logic WC_LED_GRN,
  input wire logic WC_LED_RED,
  input wire logic AES_LED_GRN,
  input wire logic AES_LED_RED
);
  logic [3:0] up_r;
  logic ctrl_wr_r;
  logic wc_d_r;
  logic [15:0] gap_r;
  wire live = (up_r == 4'hF);
  wire ctrl_wr_nxt = HSEL && HTRANS[1] && HREADY && HWRITE && (HADDR[7:0] == CTRL_OFS);

  // Checks wait out the delayed internal reset and the pin synchronisers.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      up_r <= 4'h0;
      ctrl_wr_r <= 1'b0;
    end else begin
      up_r <= live ? up_r : up_r + 4'h1;
      ctrl_wr_r <= ctrl_wr_nxt;
    end
  end

  // Cycles since the word clock pin last moved, saturating.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wc_d_r <= 1'b0;
      gap_r <= 16'hFFFF;
    end else begin
      wc_d_r <= WCLK_IN;
      gap_r <= (WCLK_IN != wc_d_r) ? 16'h0 : ((&gap_r) ? gap_r : gap_r + 16'h1);
    end
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!live);

  green_word_a: assert property (WC_LED_GRN |-> NET_SRC == SEL_WORD && !WC_LED_RED)
    else $error("word green without word source");
  red_word_a: assert property (WC_LED_RED |-> NET_SRC == SEL_INTERNAL && !WC_LED_GRN)
    else $error("word red without internal clock");
  back_word_a: assert property ($fell(WC_LED_RED) && NET_SRC == SEL_WORD |-> WC_LED_GRN)
    else $error("word source back but not green");
  green_aes_a: assert property (AES_LED_GRN |-> NET_SRC == SEL_AES && !AES_LED_RED)
    else $error("aes green without aes source");
  red_aes_a: assert property (AES_LED_RED |-> NET_SRC == SEL_INTERNAL && !AES_LED_GRN)
    else $error("aes red without internal clock");
  back_aes_a: assert property ($fell(AES_LED_RED) && NET_SRC == SEL_AES |-> AES_LED_GRN)
    else $error("aes source back but not green");
  conv_hold_a: assert property (ctrl_wr_r && HWDATA[1:0] == SEL_AES && HWDATA[CONV12_BIT]
    |=> $stable(CONV_EN) [*2])
    else $error("refused source write changed converters");
  pin_mode_a: assert property ($stable(WCLK_SW) [*4] |-> WCLK_OE == (WCLK_SW == MODE_OUT)
    && WCLK_TERM == (WCLK_SW == MODE_TERM_IN))
    else $error("connector mode outputs wrong");
  loss_early_a: assert property ($rose(WC_LED_RED) |-> gap_r >= TIMEOUT_CYC)
    else $error("word loss declared too soon");
  loss_late_a: assert property (gap_r > TIMEOUT_CYC + 8 |-> !WC_LED_GRN)
    else $error("word loss declared too late");

  word_green_c: cover property ($rose(WC_LED_GRN));
  aes_red_c: cover property ($rose(AES_LED_RED));
  out_mode_c: cover property ($rose(WCLK_OE));
endmodule

bind clk_failover clk_failover_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC), .RUN_LEN(RUN_LEN))
  chk (.*);

// *** sim/clk_failover_tb_top.sv ***
module clk_failover_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import clk_failover_pkg::*;

  logic SYS_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic CLK_EN = 1'b1;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic [1:0] WCLK_SW = 2'h0;
  logic wc_run = 1'b0;
  logic aes_run = 1'b0;
  logic [31:0] HRDATA;
  logic [31:0] rd;
  logic [1:0] NET_SRC;
  logic [1:0] CONV_EN;
  logic HREADYOUT, HRESP, WCLK_IN, AES12_IN, WCLK_OUT, WCLK_OE, WCLK_TERM, IRQ;
  logic WC_LED_GRN, WC_LED_RED, AES_LED_GRN, AES_LED_RED;
  wire HREADY = HREADYOUT;
  wire [3:0] led = {AES_LED_RED, AES_LED_GRN, WC_LED_RED, WC_LED_GRN};
  int fail_count = 0;
  int check_count = 0;

  // Short loss timeout keeps the run brief; expectations follow from it.
  clk_failover #(.TIMEOUT_CYC(40), .RUN_LEN(4)) dut (.*);
  clk_src_model wc_src (.run(wc_run), .line(WCLK_IN));
  clk_src_model aes_src (.run(aes_run), .line(AES12_IN));

  always #50 SYS_CLK = !SYS_CLK;

  // ----------
  // Helpers
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One single word transfer; read data is taken at the data phase edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    do @(posedge SYS_CLK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge SYS_CLK); while (HREADY !== 1'b1);
    rd = HRDATA;
    repeat (2) @(negedge SYS_CLK);
  endtask

  task automatic wait_led(input int k);
    repeat (300) begin
      @(posedge SYS_CLK);
      if (led[k] === 1'b1) break;
    end
    repeat (2) @(negedge SYS_CLK);
    // A wait that runs out without the indicator lit is a mismatch.
    chk(32'(led[k]), 32'h00000001);
  endtask

  // Edges between two toggles of the word clock output.
  task automatic half(input logic [31:0] n);
    logic v;
    int c;
    v = WCLK_OUT;
    repeat (50) begin
      @(posedge SYS_CLK);
      if (WCLK_OUT !== v) break;
    end
    v = WCLK_OUT;
    c = 0;
    repeat (50) begin
      @(posedge SYS_CLK);
      c++;
      if (WCLK_OUT !== v) break;
    end
    chk(32'(c), n);
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_reset;
    bus(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h0000000C);
    bus(1'b0, RATE_OFS, 32'h0);
    chk(rd, 32'h00000068);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk({led, WCLK_TERM}, 5'h01);
    chk({HREADYOUT, HRESP}, 2'h2);
    $display("reset test done");
  endtask

  task automatic t_word;
    bus(1'b1, IRQ_MASK_OFS, 32'h1F);
    bus(1'b1, CTRL_OFS, 32'h1);
    wc_run <= 1'b1;
    wait_led(0);
    chk(NET_SRC, SEL_WORD);
    bus(1'b0, STAT_OFS, 32'h0);
    chk(rd, 32'h00000005);
    chk(IRQ, 1'b1);
    bus(1'b1, IRQ_STAT_OFS, 32'h1F);
    chk(IRQ, 1'b0);
    wc_run <= 1'b0;
    wait_led(1);
    chk(NET_SRC, SEL_INTERNAL);
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    chk(rd, 32'h1);
    bus(1'b1, IRQ_MASK_OFS, 32'h0);
    chk(IRQ, 1'b0);
    bus(1'b1, IRQ_STAT_OFS, 32'h1F);
    wc_run <= 1'b1;
    wait_led(0);
    chk(led, 4'h1);
    wc_run <= 1'b0;
    wait_led(1);
    $display("word clock test done");
  endtask

  task automatic t_aes;
    bus(1'b1, IRQ_STAT_OFS, 32'h1F);
    bus(1'b1, CTRL_OFS, 32'h6);
    bus(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h1);
    bus(1'b0, IRQ_STAT_OFS, 32'h0);
    chk(rd, 32'h10);
    bus(1'b1, CTRL_OFS, 32'hA);
    chk(CONV_EN, 2'h2);
    aes_run <= 1'b1;
    wait_led(2);
    chk(NET_SRC, SEL_AES);
    aes_run <= 1'b0;
    wait_led(3);
    chk(NET_SRC, SEL_INTERNAL);
    aes_run <= 1'b1;
    wait_led(2);
    chk(led, 4'h4);
    aes_run <= 1'b0;
    wait_led(3);
    bus(1'b1, CTRL_OFS, 32'h0);
    $display("aes clock test done");
  endtask

  task automatic t_out;
    logic frz;
    @(posedge SYS_CLK);
    WCLK_SW <= MODE_OUT;
    bus(1'b1, RATE_OFS, 32'h4);
    half(32'h4);
    chk(WCLK_OE, 1'b1);
    bus(1'b1, RATE_OFS, 32'h6);
    half(32'h6);
    // With the enable low the divider must hold; 20 cycles span several half periods.
    @(posedge SYS_CLK);
    CLK_EN <= 1'b0;
    @(negedge SYS_CLK);
    frz = WCLK_OUT;
    repeat (20) @(negedge SYS_CLK);
    chk(WCLK_OUT, frz);
    @(posedge SYS_CLK);
    CLK_EN <= 1'b1;
    WCLK_SW <= MODE_OPEN_IN;
    repeat (5) @(negedge SYS_CLK);
    chk({WCLK_OE, WCLK_TERM}, 2'h0);
    $display("word clock output test done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // The whole sequence needs well under 15000 cycles.
  initial begin
    #3000000;
    fail_count++;
    print_verdict;
  end

  initial begin
    repeat (16) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    t_reset;
    t_word;
    t_aes;
    t_out;
    print_verdict;
  end
endmodule
